/* pkg/overflow_msg_pkg.sv */
// Purpose: constants and types for the monitor overflow message write block
// Assumes: byte offsets inside one feature frame, 32-bit registers
// Notes: one frame per security space, selected by the space code
package overflow_msg_pkg;

    localparam int num_spaces = 4;

    typedef enum logic [1:0]
    {
        space_secure = 2'h0,
        space_nonsecure = 2'h1,
        space_root = 2'h2,
        space_realm = 2'h3
    } space_type;

    // register byte offsets inside each frame
    localparam logic [11:0] labels_offset = 12'h8dc;
    localparam logic [11:0] addr_low_offset = 12'h8e0;
    localparam logic [11:0] addr_high_offset = 12'h8e4;
    localparam logic [11:0] payload_offset = 12'h8e8;
    localparam logic [11:0] attributes_offset = 12'h8ec;

    // field positions
    localparam int shareability_lsb = 28;
    localparam int memory_type_lsb = 24;
    localparam int enable_bit = 0;
    localparam int partition_identifier_lsb = 0;
    localparam int pmg_lsb = 16;

    // writable bits; the rest read zero
    localparam logic [31:0] attributes_mask = 32'h3f00_0001;
    localparam logic [31:0] addr_low_mask = 32'hffff_fffc;
    localparam logic [31:0] addr_high_mask = 32'h000f_ffff;
    localparam logic [31:0] labels_mask = 32'h00ff_ffff;

    // values after reset
    localparam logic [31:0] attributes_reset = 32'h0000_0000;
    localparam logic [31:0] register_reset = 32'h0000_0000;

    // shareability codes
    localparam logic [1:0] share_non = 2'h0;
    localparam logic [1:0] share_reserved = 2'h1;
    localparam logic [1:0] share_outer = 2'h2;
    localparam logic [1:0] share_inner = 2'h3;

    // memory type codes
    localparam logic [3:0] mem_device_ngnrne = 4'h0;
    localparam logic [3:0] mem_device_gre = 4'h3;
    localparam logic [1:0] cache_field_device = 2'h0;

    localparam int sync_stages = 2;

    typedef enum logic [1:0]
    {
        st_idle = 2'b01,
        st_send = 2'b10
    } send_state_type;

endpackage : overflow_msg_pkg

/* pkg/attr_decode_if.sv */
// Purpose: carries a raw attribute word to the decoder and the issued attributes back
// Assumes: purely combinational decode
// Notes: one requester, one decoder
interface attr_decode_if;
    logic [31:0] raw_attributes;
    logic [1:0] shareability;
    logic [3:0] memory_type;
    logic is_device;

    modport requester
    (
        output raw_attributes,
        input shareability,
        input memory_type,
        input is_device
    );

    modport decoder
    (
        input raw_attributes,
        output shareability,
        output memory_type,
        output is_device
    );
endinterface : attr_decode_if

/* design/msg_attr_decoder.sv */
// Purpose: turns a stored attribute word into the attributes a message write carries
// Assumes: raw word already masked to its writable bits
// Notes: combinational only
module msg_attr_decoder
    import overflow_msg_pkg::*;
(
    attr_decode_if.decoder dec
);
    logic [3:0] raw_type;
    logic [1:0] raw_share;

    assign raw_type = dec.raw_attributes[memory_type_lsb +: 4];
    assign raw_share = dec.raw_attributes[shareability_lsb +: 2];

    always_comb
    begin
        // either cacheability half zero means a device code
        dec.is_device = (raw_type[1:0] == cache_field_device) || (raw_type[3:2] == cache_field_device);
        if (raw_type[1:0] == cache_field_device)
        begin
            // reserved codes behave as the strictest device type
            dec.memory_type = mem_device_ngnrne;
        end
        else if (raw_type[3:2] == cache_field_device)
        begin
            // device codes are sent exactly as programmed, never relaxed
            dec.memory_type = raw_type;
        end
        else
        begin
            // normal memory: low pair inner, high pair outer
            dec.memory_type = raw_type;
        end
        if (dec.is_device)
        begin
            dec.shareability = share_outer;
        end
        else if (raw_share == share_reserved)
        begin
            // reserved code resolved to the safe non-shared choice
            dec.shareability = share_non;
        end
        else
        begin
            dec.shareability = raw_share;
        end
    end
endmodule : msg_attr_decoder

/* design/overflow_msg_write_config.sv */
// Purpose: per-space message write configuration and the issuing of overflow message writes
// Assumes: overflow events are one-cycle pulses from logic on clk_i
// Notes: feature straps arrive from pins and are synchronised before use
module overflow_msg_write_config
    import overflow_msg_pkg::*;
#(
    parameter int spaces = num_spaces
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic architecture_version_feature_i,
    input wire logic overflow_msg_supported_flag_i,
    input wire logic realm_management_feature_i,
    input wire logic reg_req_i,
    input wire logic reg_write_i,
    input wire logic [1:0] reg_space_i,
    input wire logic [11:0] reg_offset_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic [3:0] overflow_i,
    output logic [3:0] wired_overflow_irq_o,
    output logic msg_valid_o,
    input wire logic msg_ready_i,
    output logic [51:0] msg_addr_o,
    output logic [31:0] msg_data_o,
    output logic [1:0] msg_shareability_o,
    output logic [3:0] msg_memory_type_o,
    output logic [15:0] msg_partition_identifier_o,
    output logic [7:0] msg_perf_monitor_group_o,
    output logic [1:0] msg_space_o
);

    // the frame decode is built for exactly four spaces
    if (spaces != num_spaces)
    begin : g_bad_spaces
        $error("spaces must equal the four security spaces");
    end

    logic [1:0] reset_sync;
    logic rst_n;
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic regs_present;
    logic realm_present;
    logic space_ok;
    logic reg_hit_write;

    logic [31:0] overflow_msg_write_attributes [4];
    logic [31:0] overflow_msg_write_payload [4];
    logic [31:0] overflow_msg_write_addr_low [4];
    logic [31:0] overflow_msg_write_addr_high [4];
    logic [31:0] overflow_msg_write_labels [4];

    logic [3:0] pending;
    logic [3:0] space_enabled;
    logic [3:0] grant;
    logic [1:0] grant_space;
    logic grant_any;
    logic launch;
    send_state_type state;
    send_state_type next_state;
    logic [31:0] next_rdata;

    attr_decode_if attr_bus ();

    // reset released through two flops so all logic leaves reset together
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reset_sync <= 2'h0;
        end
        else
        begin
            reset_sync <= {reset_sync[0], 1'b1};
        end
    end
    assign rst_n = reset_sync[1];

    // straps come from pins; only the second stage is read
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
        end
        else
        begin
            strap_meta <= {realm_management_feature_i, overflow_msg_supported_flag_i,
                architecture_version_feature_i};
            strap_sync <= strap_meta;
        end
    end

    assign regs_present = strap_sync[0] && strap_sync[1];
    assign realm_present = strap_sync[2];
    // root and realm frames only exist with the realm feature
    assign space_ok = regs_present && (!reg_space_i[1] || realm_present);
    assign reg_hit_write = reg_req_i && reg_write_i && space_ok;

    // one bank per space, each written only through its own frame
    generate
        for (genvar s = 0; s < 4; s++)
        begin : g_bank
            logic sel;
            assign sel = reg_hit_write && (reg_space_i == 2'(s));

            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    overflow_msg_write_attributes[s] <= attributes_reset;
                end
                else if (sel && reg_offset_i == attributes_offset)
                begin
                    overflow_msg_write_attributes[s] <= reg_wdata_i & attributes_mask;
                end
            end

            always_ff @(posedge clk_i or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    overflow_msg_write_payload[s] <= register_reset;
                    overflow_msg_write_addr_low[s] <= register_reset;
                    overflow_msg_write_addr_high[s] <= register_reset;
                    overflow_msg_write_labels[s] <= register_reset;
                end
                else if (sel)
                begin
                    if (reg_offset_i == payload_offset)
                    begin
                        overflow_msg_write_payload[s] <= reg_wdata_i;
                    end
                    if (reg_offset_i == addr_low_offset)
                    begin
                        overflow_msg_write_addr_low[s] <= reg_wdata_i & addr_low_mask;
                    end
                    if (reg_offset_i == addr_high_offset)
                    begin
                        overflow_msg_write_addr_high[s] <= reg_wdata_i & addr_high_mask;
                    end
                    if (reg_offset_i == labels_offset)
                    begin
                        overflow_msg_write_labels[s] <= reg_wdata_i & labels_mask;
                    end
                end
            end

            assign space_enabled[s] = regs_present && overflow_msg_write_attributes[s][enable_bit];
        end
    endgenerate

    // read path; absent registers and unmapped offsets read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (reg_req_i && !reg_write_i && space_ok)
        begin
            unique case (reg_offset_i)
                attributes_offset: next_rdata = overflow_msg_write_attributes[reg_space_i];
                payload_offset: next_rdata = overflow_msg_write_payload[reg_space_i];
                addr_low_offset: next_rdata = overflow_msg_write_addr_low[reg_space_i];
                addr_high_offset: next_rdata = overflow_msg_write_addr_high[reg_space_i];
                labels_offset: next_rdata = overflow_msg_write_labels[reg_space_i];
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata_o <= 32'h0000_0000;
            reg_ack_o <= 1'b0;
        end
        else
        begin
            reg_rdata_o <= next_rdata;
            reg_ack_o <= reg_req_i;
        end
    end

    // wired interrupt only for spaces whose message writes are off
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wired_overflow_irq_o <= 4'h0;
        end
        else
        begin
            wired_overflow_irq_o <= overflow_i & ~space_enabled;
        end
    end

    // fixed priority, lowest space first; a stalled sink holds everyone back
    always_comb
    begin
        grant = 4'h0;
        grant_space = 2'h0;
        grant_any = 1'b0;
        for (int i = 3; i >= 0; i--)
        begin
            if (pending[i])
            begin
                grant = 4'h0;
                grant[i] = 1'b1;
                grant_space = i[1:0];
                grant_any = 1'b1;
            end
        end
    end

    assign launch = (state == st_idle) && grant_any;

    // a new event on the launch cycle wins over the clear
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending <= 4'h0;
        end
        else
        begin
            // disabling a space drops its queued request
            pending <= ((pending & ~(launch ? grant : 4'h0)) | overflow_i) & space_enabled;
        end
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            st_idle:
            begin
                if (grant_any)
                begin
                    next_state = st_send;
                end
            end
            st_send:
            begin
                if (msg_ready_i)
                begin
                    next_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= st_idle;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign attr_bus.raw_attributes = overflow_msg_write_attributes[grant_space];

    msg_attr_decoder u_decoder
    (
        .dec(attr_bus.decoder)
    );

    // settings are captured at launch so later register writes do not disturb a write in flight
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            msg_valid_o <= 1'b0;
            msg_addr_o <= 52'h0;
            msg_data_o <= 32'h0000_0000;
            msg_shareability_o <= share_non;
            msg_memory_type_o <= mem_device_ngnrne;
            msg_partition_identifier_o <= 16'h0000;
            msg_perf_monitor_group_o <= 8'h00;
            msg_space_o <= 2'h0;
        end
        else if (launch)
        begin
            msg_valid_o <= 1'b1;
            msg_addr_o <= {overflow_msg_write_addr_high[grant_space][19:0],
                overflow_msg_write_addr_low[grant_space][31:2], 2'h0};
            msg_data_o <= overflow_msg_write_payload[grant_space];
            msg_shareability_o <= attr_bus.shareability;
            msg_memory_type_o <= attr_bus.memory_type;
            msg_partition_identifier_o <= overflow_msg_write_labels[grant_space][partition_identifier_lsb +: 16];
            msg_perf_monitor_group_o <= overflow_msg_write_labels[grant_space][pmg_lsb +: 8];
            msg_space_o <= grant_space;
        end
        else if (state == st_send && msg_ready_i)
        begin
            msg_valid_o <= 1'b0;
        end
    end

endmodule : overflow_msg_write_config

/* testbench/overflow_msg_write_config_properties.sv */
// Purpose: port-level timing and field checks for the overflow message write block
// Assumes: register requests and events start only after the internal reset has ended
// Notes: bound to the design top below
module overflow_msg_write_config_checker
    import overflow_msg_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_req_i,
    input wire logic reg_write_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic [3:0] overflow_i,
    input wire logic [3:0] wired_overflow_irq_o,
    input wire logic msg_valid_o,
    input wire logic msg_ready_i,
    input wire logic [51:0] msg_addr_o,
    input wire logic [31:0] msg_data_o,
    input wire logic [1:0] msg_shareability_o,
    input wire logic [3:0] msg_memory_type_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    ack_after_req_a: assert property (reg_req_i |=> reg_ack_o)
        else $error("request not acknowledged one cycle later");
    ack_only_req_a: assert property (!reg_req_i |=> !reg_ack_o)
        else $error("acknowledge without a request");
    rdata_idle_zero_a: assert property (!(reg_req_i && !reg_write_i) |=> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    msg_held_a: assert property (msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_addr_o)
        && $stable(msg_data_o) && $stable(msg_memory_type_o))
        else $error("message write changed before acceptance");
    one_write_a: assert property (msg_valid_o && msg_ready_i |=> !msg_valid_o)
        else $error("message write repeated after acceptance");
    addr_aligned_a: assert property (msg_valid_o |-> msg_addr_o[1:0] == 2'h0)
        else $error("message address low bits not zero");
    device_outer_a: assert property (msg_valid_o && msg_memory_type_o[3:2] == 2'h0 |->
        msg_shareability_o == share_outer)
        else $error("device write not outer shareable");
    reserved_type_a: assert property (msg_valid_o |-> !(msg_memory_type_o inside {4'h4, 4'h8, 4'hc}))
        else $error("reserved memory type issued");
    wired_cause_a: assert property (wired_overflow_irq_o != 4'h0 |->
        (wired_overflow_irq_o & ~$past(overflow_i)) == 4'h0)
        else $error("wired interrupt without an event");
endmodule : overflow_msg_write_config_checker

bind overflow_msg_write_config overflow_msg_write_config_checker i_checker
(
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .reg_req_i(reg_req_i),
    .reg_write_i(reg_write_i),
    .reg_rdata_o(reg_rdata_o),
    .reg_ack_o(reg_ack_o),
    .overflow_i(overflow_i),
    .wired_overflow_irq_o(wired_overflow_irq_o),
    .msg_valid_o(msg_valid_o),
    .msg_ready_i(msg_ready_i),
    .msg_addr_o(msg_addr_o),
    .msg_data_o(msg_data_o),
    .msg_shareability_o(msg_shareability_o),
    .msg_memory_type_o(msg_memory_type_o)
);

/* testbench/msg_sink_model.sv */
// Purpose: interconnect sink that accepts overflow message writes
// Assumes: ready may change only after a clock edge
// Notes: stalling accepts every fourth waiting cycle so held requests get exercised
module msg_sink_model
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic stall_i,
    input wire logic msg_valid_i,
    output logic msg_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_count;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            wait_count <= 2'h0;
        else if (msg_valid_i)
            wait_count <= wait_count + 2'h1;
    end

    assign msg_ready_o = !stall_i || (wait_count == 2'h3);
endmodule : msg_sink_model

/* testbench/tb_overflow_msg_write_config.sv */
// Purpose: self-checking bench for the overflow message write configuration block
// Assumes: straps change only while the register port is quiet
// Notes: inputs move on the falling edge; expectations come from the bench's own functions
module tb_overflow_msg_write_config
    import overflow_msg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] offs_tab [5] = '{labels_offset, addr_low_offset, addr_high_offset,
        payload_offset, attributes_offset};
    localparam logic [31:0] mask_tab [5] = '{labels_mask, addr_low_mask, addr_high_mask, 32'hffff_ffff,
        attributes_mask};
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ver_f = 1'b1;
    logic flag_f = 1'b1;
    logic realm_f = 1'b1;
    logic req = 1'b0;
    logic wr = 1'b0;
    logic [1:0] space = 2'h0;
    logic [11:0] offs = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] ovf = 4'h0;
    logic stall = 1'b0;
    logic [31:0] rdata;
    logic ack;
    logic [3:0] wired;
    logic valid;
    logic ready;
    logic [51:0] addr;
    logic [31:0] data;
    logic [1:0] sh;
    logic [3:0] mem;
    logic [15:0] part;
    logic [7:0] perf_monitor_group;
    logic [1:0] msp;
    logic [31:0] lfsr_state = 32'h0001_49ef;
    logic [31:0] scratch;
    logic [31:0] shadow [4][5];
    logic [115:0] got [$];
    int num_errors = 0;
    int n_tests = 0;

    overflow_msg_write_config i_dut
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .architecture_version_feature_i(ver_f),
        .overflow_msg_supported_flag_i(flag_f),
        .realm_management_feature_i(realm_f),
        .reg_req_i(req),
        .reg_write_i(wr),
        .reg_space_i(space),
        .reg_offset_i(offs),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .reg_ack_o(ack),
        .overflow_i(ovf),
        .wired_overflow_irq_o(wired),
        .msg_valid_o(valid),
        .msg_ready_i(ready),
        .msg_addr_o(addr),
        .msg_data_o(data),
        .msg_shareability_o(sh),
        .msg_memory_type_o(mem),
        .msg_partition_identifier_o(part),
        .msg_perf_monitor_group_o(perf_monitor_group),
        .msg_space_o(msp)
    );

    msg_sink_model i_sink
    (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .stall_i(stall),
        .msg_valid_i(valid),
        .msg_ready_o(ready)
    );

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // outputs are stable between rising edges, so each accepted write is seen exactly once
    always @(negedge clk_i)
    begin
        if (valid && ready)
            got.push_back({msp, sh, mem, part, perf_monitor_group, data, addr});
    end

    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++)
            lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return lfsr_state;
    endfunction : rnd

    function automatic logic present(input logic [1:0] s);
        return ver_f && flag_f && (!s[1] || realm_f);
    endfunction : present

    function automatic logic [115:0] exp_msg(input int s);
        logic [31:0] a;
        logic [3:0] m;
        logic [1:0] h;
        a = shadow[s][4];
        m = (a[27:24] inside {4'h4, 4'h8, 4'hc}) ? 4'h0 : a[27:24];
        h = (m[3:2] == 2'h0) ? share_outer : ((a[29:28] == share_reserved) ? share_non : a[29:28]);
        return {2'(s), h, m, shadow[s][0][15:0], shadow[s][0][23:16], shadow[s][3], shadow[s][2][19:0],
            shadow[s][1][31:2], 2'h0};
    endfunction : exp_msg

    task automatic give_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [127:0] seen, input logic [127:0] want);
        n_tests++;
        if (seen !== want)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    task automatic reg_op(input logic [1:0] s, input logic [11:0] o, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        @(negedge clk_i);
        req = 1'b1;
        wr = w;
        space = s;
        offs = o;
        wdata = d;
        @(negedge clk_i);
        req = 1'b0;
        check(ack, 1'b1);
        q = rdata;
    endtask : reg_op

    task automatic rd_reg(input int s, input int r);
        logic [31:0] q;
        reg_op(2'(s), offs_tab[r], 1'b0, 32'h0, q);
        check(q, present(2'(s)) ? shadow[s][r] : 32'h0);
    endtask : rd_reg

    task automatic wr_reg(input int s, input int r, input logic [31:0] d);
        logic [31:0] q;
        reg_op(2'(s), offs_tab[r], 1'b1, d, q);
        if (present(2'(s)))
            shadow[s][r] = d & mask_tab[r];
    endtask : wr_reg

    task automatic wait_msgs(input int n);
        for (int k = 0; k < 40 && (k < 8 || got.size() < n); k++)
            @(negedge clk_i);
        check(got.size(), n);
        if (got.size() < n)
            give_verdict();
    endtask : wait_msgs

    task automatic msg_case(input int s, input logic [31:0] a);
        wr_reg(s, 4, a);
        @(negedge clk_i);
        ovf[s] = 1'b1;
        @(negedge clk_i);
        ovf = 4'h0;
        check(wired[s], !a[0]);
        wait_msgs(a[0]);
        if (a[0])
            check(got.pop_front(), exp_msg(s));
    endtask : msg_case

    initial
    begin
        foreach (shadow[s, r])
            shadow[s][r] = 32'h0;
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        repeat (6) @(negedge clk_i);
        for (int p = 0; p < 3; p++)
            for (int k = 0; k < 20; k++)
                if (p == 1)
                    wr_reg(k / 5, k % 5, rnd());
                else
                    rd_reg(k / 5, k % 5);
        wr_reg(1, 4, 32'h1000_0000);
        reg_op(2'h1, 12'h8f0, 1'b1, rnd(), scratch);
        reg_op(2'h1, 12'h8f0, 1'b0, 32'h0, scratch);
        check(scratch, 32'h0);
        for (int c = 0; c < 16; c++)
            msg_case(c % 4, (rnd() & 32'hf0ff_fffe) | (c << 24) | 32'h1);
        msg_case(2, rnd() & 32'hffff_fffe);
        stall = 1'b1;
        wr_reg(0, 4, 32'h0500_0001);
        wr_reg(1, 4, 32'h0f00_0001);
        @(negedge clk_i);
        ovf = 4'h3;
        @(negedge clk_i);
        ovf = 4'h0;
        wait_msgs(2);
        check(got.pop_front(), exp_msg(0));
        check(got.pop_front(), exp_msg(1));
        stall = 1'b0;
        ver_f = 1'b0;
        repeat (4) @(negedge clk_i);
        wr_reg(1, 3, rnd());
        rd_reg(1, 3);
        ver_f = 1'b1;
        flag_f = 1'b0;
        repeat (4) @(negedge clk_i);
        rd_reg(1, 3);
        flag_f = 1'b1;
        realm_f = 1'b0;
        repeat (4) @(negedge clk_i);
        rd_reg(1, 3);
        wr_reg(3, 3, rnd());
        rd_reg(3, 0);
        realm_f = 1'b1;
        repeat (4) @(negedge clk_i);
        rd_reg(3, 3);
        give_verdict();
    end
endmodule : tb_overflow_msg_write_config
